/* File: logic/hbp_pkg.sv */
package hbp_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_CH   = 8;
	localparam int NUM_PAIR = 4;
	localparam int DW       = 11;
	localparam int AW       = 8;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_PERIOD     = 8'h04;
	localparam logic [7:0] OFS_STATUS     = 8'h08;
	localparam logic [2:0] REGION_MISC    = 3'h0;
	localparam logic [2:0] REGION_CHCTL   = 3'h1;
	localparam logic [2:0] REGION_DUTY    = 3'h2;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CTRL_FAST_BIT   = 0;
	localparam int CTRL_LOW_SIDE_RECIRCULATION_SELECT_BIT = 1;
	localparam int DUTY_SIGN_BIT   = 15;
	localparam int STATUS_CNT_LSB  = 16;
	localparam logic [15:0] PERIOD_RST = 16'h0000;
	localparam logic [15:0] DUTY_RST   = 16'h0000;
	localparam logic [7:0]  CHCTL_RST  = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ****************************************
	// modes
	// ****************************************
	typedef enum logic [1:0] {
		OM_HALF_MINUS = 2'h0,
		OM_HALF_PLUS  = 2'h1,
		OM_FULL       = 2'h2,
		OM_DUAL       = 2'h3
	} hbp_mode_e;

	typedef enum logic [1:0] {
		AL_OFF    = 2'h0,
		AL_LEFT   = 2'h1,
		AL_RIGHT  = 2'h2,
		AL_CENTER = 2'h3
	} hbp_align_e;

	typedef struct packed {
		logic [NUM_CH-1:0] plus_out;
		logic [NUM_CH-1:0] plus_oe;
		logic [NUM_CH-1:0] minus_out;
		logic [NUM_CH-1:0] minus_oe;
	} hbp_pins_s;
endpackage : hbp_pkg

/* File: logic/hbp_pwm.sv */
`timescale 1ns/1ps
// What this block does
// - duty counts timer clocks at active level; active low if low_side_recirculation_select 0, else high in full modes; always low in half
// - zero duty gives a constant inactive output
// - duty at or above period gives a constant active output
// - duty is D[10:0] normally, D[8:2] in high byte when high-byte mode on
// - high-byte mode writes force D10, D9, D1, D0 to zero
// - toggling high-byte mode leaves stored duty meaning unchanged
// - working copy taken at period 0, channel disabled, or overflow in half/full
// - dual pair loads working duty only at overflow after odd register write, or while period is 0
// - reads return last written value, not the working one
// - sign with low_side_recirculation_select picks the pwm pin in full modes; ignored in half
// - after reset all channels disabled and all pins released
// - non-pwm pin static per low_side_recirculation_select in full modes, released in half mode
// - pair n holds channel 2n on coil 0 pins and 2n+1 on coil 1 pins
// - dual mode only when both channels enabled and both modes are 11
// - high-byte mode accepts a high-byte write as a full duty update
// - repeated writes before transfer keep only the latest value
// - full mode channels independent, working duty refreshed every overflow
// - released pin in half mode is left to other functions
// - output mode 00 half minus, 01 half plus, 10 full, 11 dual
// - alignment 00 off, 01 left, 10 right, 11 center
// - period gives timer clocks per pwm period
module hbp_pwm
	import hbp_pkg::*;
#(
	parameter int TC_DIV = 1
)(
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite write
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	// axi4-lite read
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	// bridge pins
	output hbp_pins_s          pins
);
	// ****************************************
	// bus slave
	// ****************************************
	logic          aw_held;
	logic          w_held;
	logic [AW-1:0] aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          wr_go;
	logic          wr_hit;
	logic          rd_hit;

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = (a[1:0] == 2'h0) && ((a[7:5] == REGION_CHCTL) || (a[7:5] == REGION_DUTY)
			|| (a == OFS_CTRL) || (a == OFS_PERIOD) || (a == OFS_STATUS));
	endfunction : mapped

	assign awready = !aw_held && !bvalid;
	assign wready  = !w_held && !bvalid;
	assign wr_go   = aw_held && w_held && !bvalid;
	assign wr_hit  = mapped(aw_addr);
	assign arready = !rvalid;
	assign rd_hit  = mapped(araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic              fast;
	logic              low_side_recirculation_select;
	logic [DW-1:0]     per;
	logic [7:0]        chctl [NUM_CH];
	logic              bus_s [NUM_CH];
	logic [DW-1:0]     bus_d [NUM_CH];
	logic              work_s [NUM_CH];
	logic [DW-1:0]     work_d [NUM_CH];
	logic [NUM_PAIR-1:0] pend;
	logic [NUM_PAIR-1:0] dual;
	logic [DW-1:0]     cnt;
	logic              odd_period;
	logic              ovf;
	logic [2:0]        wr_ch;
	logic              duty_wr;

	assign wr_ch   = aw_addr[4:2];
	assign duty_wr = wr_go && wr_hit && (aw_addr[7:5] == REGION_DUTY);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast   <= 1'b0;
			low_side_recirculation_select <= 1'b0;
			per    <= PERIOD_RST[DW-1:0];
		end else if (wr_go && w_strb[0] && aw_addr == OFS_CTRL) begin
			fast   <= w_data[CTRL_FAST_BIT];
			low_side_recirculation_select <= w_data[CTRL_LOW_SIDE_RECIRCULATION_SELECT_BIT];
		end else if (wr_go && aw_addr == OFS_PERIOD) begin
			if (w_strb[0])
				per[7:0] <= w_data[7:0];
			if (w_strb[1])
				per[DW-1:8] <= w_data[DW-1:8];
		end
	end

	// fast only changes how writes and reads map; stored duty keeps its meaning
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				chctl[i] <= CHCTL_RST;
				bus_s[i] <= DUTY_RST[DUTY_SIGN_BIT];
				bus_d[i] <= DUTY_RST[DW-1:0];
			end
		end else if (wr_go && wr_hit) begin
			if (aw_addr[7:5] == REGION_CHCTL && w_strb[0])
				chctl[wr_ch] <= w_data[7:0];
			if (duty_wr && fast && w_strb[1]) begin
				bus_s[wr_ch] <= w_data[DUTY_SIGN_BIT];
				bus_d[wr_ch] <= {2'h0, w_data[14:8], 2'h0};
			end else if (duty_wr && !fast) begin
				if (w_strb[1]) begin
					bus_s[wr_ch]       <= w_data[DUTY_SIGN_BIT];
					bus_d[wr_ch][10:8] <= w_data[10:8];
				end
				if (w_strb[0])
					bus_d[wr_ch][7:0] <= w_data[7:0];
			end
		end
	end

	// read data mirror the bus copy in the current layout
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata  <= '0;
			if (araddr == OFS_CTRL)
				rdata[1:0] <= {low_side_recirculation_select, fast};
			else if (araddr == OFS_PERIOD)
				rdata[DW-1:0] <= per;
			else if (araddr == OFS_STATUS)
				rdata <= {5'h0, cnt, 8'h0, pend, dual};
			else if (rd_hit && araddr[7:5] == REGION_CHCTL)
				rdata[7:0] <= chctl[araddr[4:2]];
			else if (rd_hit && araddr[7:5] == REGION_DUTY && fast)
				rdata[15:0] <= {bus_s[araddr[4:2]], bus_d[araddr[4:2]][8:2], 8'h0};
			else if (rd_hit && araddr[7:5] == REGION_DUTY)
				rdata[15:0] <= {bus_s[araddr[4:2]], 4'h0, bus_d[araddr[4:2]]};
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ****************************************
	// timer counter
	// ****************************************
	logic [15:0] div;
	logic        tick;

	assign tick = (div == 16'(TC_DIV - 1));
	assign ovf  = tick && (per != '0) && (cnt >= per - 11'h1);

	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			div <= '0;
		else
			div <= div + 16'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || per == '0) begin
			cnt        <= '0;
			odd_period <= 1'b0;
		end else if (ovf) begin
			cnt        <= '0;
			odd_period <= !odd_period;
		end else if (tick) begin
			cnt <= cnt + 11'h1;
		end
	end

	// ****************************************
	// double buffering
	// ****************************************
	always_comb begin
		for (int p = 0; p < NUM_PAIR; p++)
			dual[p] = chctl[2*p][5:4] != AL_OFF && chctl[2*p+1][5:4] != AL_OFF
				&& chctl[2*p][7:6] == OM_DUAL && chctl[2*p+1][7:6] == OM_DUAL;
	end

	// an odd channel write landing on the overflow cycle keeps its pair pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend <= '0;
		end else begin
			for (int p = 0; p < NUM_PAIR; p++)
				if (duty_wr && wr_ch == 3'(2*p+1))
					pend[p] <= 1'b1;
				else if (ovf && dual[p])
					pend[p] <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				work_s[i] <= 1'b0;
				work_d[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++)
				if (per == '0 || chctl[i][5:4] == AL_OFF
					|| (ovf && (dual[i/2] ? pend[i/2] : 1'b1))) begin
					work_s[i] <= bus_s[i];
					work_d[i] <= bus_d[i];
				end
		end
	end

	// ****************************************
	// waveform and pins
	// ****************************************
	logic [NUM_CH-1:0] act;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (work_d[i] == '0)
				act[i] = 1'b0;
			else if (work_d[i] >= per)
				act[i] = 1'b1;
			else if (chctl[i][5:4] == AL_RIGHT
				|| (chctl[i][5:4] == AL_CENTER && odd_period))
				act[i] = cnt >= per - work_d[i];
			else
				act[i] = cnt < work_d[i];
		end
	end

	// registered pins; output modes with one dual channel run as full
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				pins.plus_oe[i]   <= 1'b0;
				pins.minus_oe[i]  <= 1'b0;
				pins.plus_out[i]  <= 1'b0;
				pins.minus_out[i] <= 1'b0;
				if (per != '0 && chctl[i][5:4] != AL_OFF) begin
					unique case (chctl[i][7:6])
						OM_HALF_MINUS: begin
							pins.minus_oe[i]  <= 1'b1;
							pins.minus_out[i] <= !act[i];
						end
						OM_HALF_PLUS: begin
							pins.plus_oe[i]  <= 1'b1;
							pins.plus_out[i] <= !act[i];
						end
						OM_FULL, OM_DUAL: begin
							pins.plus_oe[i]  <= 1'b1;
							pins.minus_oe[i] <= 1'b1;
							if (work_s[i] == low_side_recirculation_select) begin
								pins.minus_out[i] <= low_side_recirculation_select ? act[i] : !act[i];
								pins.plus_out[i]  <= !low_side_recirculation_select;
							end else begin
								pins.plus_out[i]  <= low_side_recirculation_select ? act[i] : !act[i];
								pins.minus_out[i] <= !low_side_recirculation_select;
							end
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_reset_release;
		@(posedge aclk) !aresetn |=> (pins.plus_oe == '0 && pins.minus_oe == '0);
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("pins driven after reset");

	property p_zero_duty;
		@(posedge aclk) disable iff (!aresetn)
		(per != '0 && chctl[0][7:6] == OM_FULL && chctl[0][5:4] == AL_LEFT
			&& work_d[0] == '0 && !low_side_recirculation_select && !work_s[0])
		|=> (pins.minus_out[0] && pins.plus_out[0] && pins.minus_oe[0]);
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("zero duty not inactive");

	property p_full_duty;
		@(posedge aclk) disable iff (!aresetn)
		(per != '0 && chctl[0][7:6] == OM_FULL && chctl[0][5:4] == AL_LEFT
			&& work_d[0] >= per && low_side_recirculation_select && !work_s[0])
		|=> (pins.plus_out[0] && !pins.minus_out[0]);
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("full duty not active");

	property p_fast_clear;
		@(posedge aclk) disable iff (!aresetn)
		(duty_wr && fast && w_strb[1]) |=> (bus_d[$past(wr_ch)][10:9] == 2'h0
			&& bus_d[$past(wr_ch)][1:0] == 2'h0);
	endproperty
	a_fast_clear: assert property (p_fast_clear) else $error("fast write kept low bits");

	property p_copy_when_off;
		@(posedge aclk) disable iff (!aresetn)
		(per == '0) ##1 (per == '0) |-> (work_d[3] == $past(bus_d[3]));
	endproperty
	a_copy_when_off: assert property (p_copy_when_off) else $error("no copy at period 0");

	property p_dual_hold;
		@(posedge aclk) disable iff (!aresetn)
		(dual[1] && !pend[1] && !(per == '0)) |=> (work_d[2] == $past(work_d[2]));
	endproperty
	a_dual_hold: assert property (p_dual_hold) else $error("dual pair loaded early");

	property p_half_release;
		@(posedge aclk) disable iff (!aresetn)
		(chctl[1][7:6] == OM_HALF_MINUS) |=> !pins.plus_oe[1];
	endproperty
	a_half_release: assert property (p_half_release) else $error("half mode drove plus");

	property p_full_refresh;
		@(posedge aclk) disable iff (!aresetn)
		(ovf && chctl[0][7:6] == OM_FULL) |=> (work_d[0] == $past(bus_d[0]));
	endproperty
	a_full_refresh: assert property (p_full_refresh) else $error("full mode not refreshed");

	property p_read_back;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && araddr == 8'h40 && !fast)
		|=> (rvalid && rdata[10:0] == $past(bus_d[0]));
	endproperty
	a_read_back: assert property (p_read_back) else $error("read not last written");
endmodule : hbp_pwm

/* File: tb/hbp_bridge_model.sv */
`timescale 1ns/1ps
module hbp_bridge_model
	import hbp_pkg::*;
#(
	parameter logic PULL = 1'b0
)(
	// pins from the block
	input  wire hbp_pins_s         pins,
	// coil terminal levels
	output logic [NUM_CH-1:0]     plus_lvl,
	output logic [NUM_CH-1:0]     minus_lvl
);
	// ****************************************
	// terminals
	// ****************************************
	// a released pin falls to the pull level, never keeps its last value
	assign plus_lvl  = (pins.plus_oe & pins.plus_out) | (~pins.plus_oe & {NUM_CH{PULL}});
	assign minus_lvl = (pins.minus_oe & pins.minus_out) | (~pins.minus_oe & {NUM_CH{PULL}});
endmodule : hbp_bridge_model

/* File: tb/hbp_pwm_tb_top.sv */
`timescale 1ns/1ps
module hbp_pwm_tb_top
	import hbp_pkg::*;
;
	// ****************************************
	// clock, reset, dut
	// ****************************************
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [AW-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [31:0] d;
	hbp_pins_s pins;
	logic [NUM_CH-1:0] plus_lvl, minus_lvl;
	int mismatches, num_checks;

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	hbp_pwm #(.TC_DIV(1)) u_hbp_pwm (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pins(pins));
	hbp_bridge_model u_hbp_bridge_model (.pins(pins), .plus_lvl(plus_lvl),
		.minus_lvl(minus_lvl));

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// ready is sampled before the edge, so the release never races the handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s,
		output logic [1:0] rs);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dd;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50 && !tb; i++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		chk("bvalid", 32'h1, {31'h0, tb});
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rs);
		logic ta, tr;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50 && !tr; i++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			dd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		chk("rvalid", 32'h1, {31'h0, tr});
		rready <= 1'b0;
	endtask : rd

	task automatic w(input logic [7:0] a, input logic [31:0] dd);
		wr(a, dd, 4'hf, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask : w

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a, d, r);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
		chk(nm, e, d);
	endtask : rc

	task automatic cfg(input logic [2:0] ch, input hbp_mode_e m, input hbp_align_e al);
		w({3'h1, ch, 2'h0}, {24'h0, m, al, 4'h0});
	endtask : cfg

	task automatic dty(input logic [2:0] ch, input logic s, input logic [10:0] v);
		w({3'h2, ch, 2'h0}, {16'h0, s, 4'h0, v});
		repeat (25) @(posedge aclk);
	endtask : dty

	// counts over one period of ten timer clocks
	task automatic pc(input int ch, input int ph, input int mh, input int po, input int mo);
		int c[4] = '{default: 0};
		repeat (10) begin
			@(negedge aclk);
			c[0] += plus_lvl[ch];
			c[1] += minus_lvl[ch];
			c[2] += pins.plus_oe[ch];
			c[3] += pins.minus_oe[ch];
		end
		chk("plus_high", 32'(ph), 32'(c[0]));
		chk("minus_high", 32'(mh), 32'(c[1]));
		chk("plus_oe", 32'(po), 32'(c[2]));
		chk("minus_oe", 32'(mo), 32'(c[3]));
	endtask : pc

	// level changes of the plus pin over twenty timer clocks; tells center from edge aligned
	task automatic ed(input int ch, input int e);
		int n;
		logic lv;
		n = 0;
		@(negedge aclk);
		lv = plus_lvl[ch];
		repeat (20) begin
			@(negedge aclk);
			n += (plus_lvl[ch] != lv);
			lv = plus_lvl[ch];
		end
		chk("plus_edges", 32'(e), 32'(n));
	endtask : ed

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		for (int i = 0; i < 8; i++) begin
			pc(i, 0, 0, 0, 0);
			rc({3'h2, 3'(i), 2'h0}, 32'(DUTY_RST), "duty_rst");
			w({3'h2, 3'(i), 2'h0}, 32'h8000 | 32'(i * 'h111));
			rc({3'h2, 3'(i), 2'h0}, 32'h8000 | 32'(i * 'h111), "duty");
		end
		wr(8'hfc, 32'h1, 4'hf, r);
		chk("bresp", 32'(RESP_SLVERR), 32'(r));
		rd(8'hfc, d, r);
		chk("rresp", 32'(RESP_SLVERR), 32'(r));
		$display("test regs done");
	endtask : t_regs

	task automatic t_fast();
		dty(2, 1'b0, 11'h7ff);
		w(OFS_CTRL, 32'h1);
		wr(8'h48, 32'h5600, 4'h2, r);
		rc(8'h48, 32'h5600, "duty_fast");
		w(OFS_CTRL, 32'h0);
		rc(8'h48, 32'h0158, "duty_norm");
		dty(2, 1'b0, 11'h003);
		w(OFS_CTRL, 32'h1);
		rc(8'h48, 32'h0, "duty_fast");
		w(OFS_CTRL, 32'h0);
		rc(8'h48, 32'h3, "duty_norm");
		$display("test fast done");
	endtask : t_fast

	task automatic t_modes();
		int pw, st;
		w(OFS_PERIOD, 32'd10);
		cfg(0, OM_FULL, AL_LEFT);
		for (int k = 0; k < 4; k++) begin
			pw = k[1] ? 3 : 7;
			st = k[1] ? 0 : 10;
			w(OFS_CTRL, {30'h0, k[1], 1'b0});
			dty(0, k[0], 11'd3);
			if (k[0] == k[1]) pc(0, st, pw, 10, 10);
			else pc(0, pw, st, 10, 10);
		end
		w(OFS_CTRL, 32'h0);
		dty(0, 1'b0, 11'd0);
		pc(0, 10, 10, 10, 10);
		dty(0, 1'b0, 11'd12);
		pc(0, 10, 0, 10, 10);
		w(OFS_CTRL, 32'h2);
		pc(0, 10, 0, 10, 10);
		w(OFS_CTRL, 32'h0);
		cfg(1, OM_HALF_MINUS, AL_LEFT);
		dty(1, 1'b1, 11'd3);
		pc(1, 0, 7, 0, 10);
		cfg(1, OM_HALF_PLUS, AL_RIGHT);
		repeat (25) @(posedge aclk);
		pc(1, 7, 0, 10, 0);
		ed(1, 4);
		cfg(1, OM_HALF_PLUS, AL_CENTER);
		ed(1, 2);
		cfg(1, OM_HALF_PLUS, AL_OFF);
		pc(1, 0, 0, 0, 0);
		$display("test modes done");
	endtask : t_modes

	task automatic t_dual();
		cfg(2, OM_DUAL, AL_LEFT);
		cfg(3, OM_DUAL, AL_LEFT);
		dty(2, 1'b0, 11'd3);
		dty(3, 1'b0, 11'd3);
		pc(2, 10, 7, 10, 10);
		dty(2, 1'b0, 11'd8);
		dty(2, 1'b0, 11'd6);
		pc(2, 10, 7, 10, 10);
		rc(8'h48, 32'd6, "duty_pend");
		dty(3, 1'b0, 11'd5);
		pc(2, 10, 4, 10, 10);
		pc(3, 10, 5, 10, 10);
		rd(OFS_STATUS, d, r);
		chk("dual_on", 32'h1, {31'h0, d[1]});
		cfg(3, OM_FULL, AL_LEFT);
		dty(2, 1'b0, 11'd2);
		pc(2, 10, 8, 10, 10);
		rd(OFS_STATUS, d, r);
		chk("dual_on", 32'h0, {31'h0, d[1]});
		w(OFS_PERIOD, 32'd0);
		pc(2, 0, 0, 0, 0);
		$display("test dual done");
	endtask : t_dual

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_fast();
		t_modes();
		t_dual();
		test_done();
	end

	// the whole run needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		test_done();
	end
endmodule : hbp_pwm_tb_top
